// ==== src/cpu_core_map.sv ====
// Core register file, data-space map, fetch pipeline, stack push, clock and sleep control.
// Assumes program memory answers in the same cycle as its address and SRAM one cycle after; fuses are static.
//
// Functional notes
// [RQ1] Reset pin low for two running cycles resets; outside must hold it that long.
// [RQ2] Crystal variant start-up delay is 1 ms or 16 ms by fuse.
// [RQ3] RC variant uses internal RC when select fuse is programmed low.
// [RQ4] External clock on RC variant takes port bit three away from I/O.
// [RQ5] 32 eight-bit registers, two operand reads and one write each cycle.
// [RQ6] Six registers form three 16-bit pointers; one also addresses constant tables.
// [RQ7] Registers appear as the lowest 32 data-space addresses.
// [RQ8] 64 I/O locations reachable directly or right after the register file.
// [RQ9] Two-stage pipeline prefetches next instruction while current one executes.
// [RQ10] One or two word instructions; relative jumps reach all 1K words.
// [RQ11] Calls and interrupts push the return address onto the SRAM stack.
// [RQ12] Eight-bit stack pointer in I/O space; software sets it before calls.
// [RQ13] Idle halts the CPU while memory, peripherals and interrupts keep running.
// [RQ14] Power-down stops the oscillator, keeps registers until interrupt or reset.
// [RQ15] Port is three bits on crystal variant, five on RC variant, per-bit pull-ups.
// [RQ16] Reset qualified by counting consecutive low samples on the running clock.
`timescale 1ns/1ns
`default_nettype none
module cpu_core_map
   import core_map_pkg::*;
#(
   parameter int XTAL_SHORT_COUNT = XTAL_SHORT_CYC,
   parameter int XTAL_LONG_COUNT  = XTAL_LONG_CYC
)(
   input  wire logic                i_clk,
   input  wire logic                i_reset,
   input  wire logic                i_ce,
   input  wire logic                i_reset_pin_n,
   input  wire logic                i_variant_rc,
   input  wire logic                i_rc_oscillator_select_fuse,
   input  wire logic                i_start_long_fuse,
   input  wire logic [15:0]         i_prog_word,
   output logic      [PC_W-1:0]     o_prog_addr,
   output logic      [15:0]         o_exec_instr,
   output logic                     o_exec_valid,
   output logic      [PC_W-1:0]     o_exec_pc,
   input  wire logic                i_jump,
   input  wire logic                i_call,
   input  wire logic [11:0]         i_rel_off,
   input  wire logic                i_irq_take,
   input  wire logic [PC_W-1:0]     i_irq_vector,
   input  wire logic                i_irq_req,
   input  wire logic                i_sleep_req,
   input  wire logic                i_sleep_pdown,
   input  wire logic                i_rf_we,
   input  wire logic [4:0]          i_rf_wr_idx,
   input  wire logic [REG_W-1:0]    i_rf_wdata,
   input  wire logic [4:0]          i_rf_rd_a,
   input  wire logic [4:0]          i_rf_rd_b,
   output logic      [REG_W-1:0]    o_op_a,
   output logic      [REG_W-1:0]    o_op_b,
   output logic      [15:0]         o_ptr_x,
   output logic      [15:0]         o_ptr_y,
   output logic      [15:0]         o_ptr_z,
   output logic      [15:0]         o_table_addr,
   input  wire logic                i_dacc_en,
   input  wire logic                i_dacc_we,
   input  wire logic                i_dacc_io,
   input  wire logic [ADDR_W-1:0]   i_dacc_addr,
   input  wire logic [REG_W-1:0]    i_dacc_wdata,
   output logic      [REG_W-1:0]    o_dacc_rdata,
   output logic                     o_io_en,
   output logic                     o_io_we,
   output logic      [5:0]          o_io_addr,
   output logic      [REG_W-1:0]    o_io_wdata,
   input  wire logic [REG_W-1:0]    i_io_rdata,
   output logic                     o_sram_en,
   output logic                     o_sram_we,
   output logic      [REG_W-1:0]    o_sram_addr,
   output logic      [REG_W-1:0]    o_sram_wdata,
   input  wire logic [REG_W-1:0]    i_sram_rdata,
   output logic      [REG_W-1:0]    o_stack_pointer,
   input  wire logic [PORT_MAX-1:0] i_port_out,
   input  wire logic [PORT_MAX-1:0] i_port_dir,
   input  wire logic [PORT_MAX-1:0] i_port_pull,
   input  wire logic [PORT_MAX-1:0] i_port_pin,
   output logic      [PORT_MAX-1:0] o_port_o,
   output logic      [PORT_MAX-1:0] o_port_oe,
   output logic      [PORT_MAX-1:0] o_port_pu,
   output logic      [PORT_MAX-1:0] o_port_in,
   output core_status_s             o_status,
   output logic                     o_core_reset,
   output logic                     o_cpu_running
);
   logic core_reset;

   reset_qualifier #(.LOW_CYCLES(RESET_LOW_CYCLES)) u_rst_q (
      .i_clk         (i_clk),
      .i_reset       (i_reset),
      .i_ce          (i_ce),
      .i_reset_pin_n (i_reset_pin_n),
      .o_core_reset  (core_reset)
   );

   function automatic logic [START_W-1:0] start_cycles(input logic rc, input logic long_sel);
      if (rc)
         start_cycles = START_W'(RC_START_CYC);
      else if (long_sel)
         start_cycles = START_W'(XTAL_LONG_COUNT); // RQ2
      else
         start_cycles = START_W'(XTAL_SHORT_COUNT); // RQ2
   endfunction

   function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base,
                                                 input logic [11:0] k);
      // Wraps modulo 1K words, so every word is reachable
      rel_target = base + k[PC_W-1:0] + PC_W'(1); // RQ10
   endfunction

   function automatic logic [1:0] region_of(input logic io_direct, input logic [ADDR_W-1:0] a);
      if (io_direct || (a >= IO_SPACE_BASE && a <= IO_SPACE_END))
         region_of = REGION_IO; // RQ8
      else if (a <= REG_SPACE_END)
         region_of = REGION_RF; // RQ7
      else
         region_of = REGION_SRAM;
   endfunction

   function automatic logic [5:0] io_index(input logic io_direct, input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] off;
      off = a - IO_SPACE_BASE;
      io_index = io_direct ? a[5:0] : off[5:0]; // RQ8
   endfunction

   core_state_e     state_ff, nxt_state;
   logic [START_W-1:0] start_cnt_ff, nxt_start;
   logic [PC_W-1:0] pc_ff, nxt_pc, exec_pc_ff, nxt_exec_pc, ret_ff, nxt_ret;
   logic [15:0]     instr_ff, nxt_instr;
   logic            valid_ff, nxt_valid;
   logic [REG_W-1:0] sp_ff, nxt_sp;
   logic            variant_ff, nxt_variant, rc_fuse_ff, nxt_rc_fuse, long_ff, nxt_long;
   logic            push_we;
   logic [REG_W-1:0] push_data;
   logic            cpu_active, dacc_ok;
   logic [1:0]      region;
   logic [5:0]      io_idx;

   assign cpu_active = (state_ff == ST_RUN);
   assign dacc_ok    = i_dacc_en & cpu_active;
   assign region     = region_of(i_dacc_io, i_dacc_addr);
   assign io_idx     = io_index(i_dacc_io, i_dacc_addr);

   always_comb
   begin
      nxt_state   = state_ff;
      nxt_start   = start_cnt_ff;
      nxt_pc      = pc_ff;
      nxt_exec_pc = exec_pc_ff;
      nxt_instr   = instr_ff;
      nxt_valid   = valid_ff;
      nxt_ret     = ret_ff;
      nxt_sp      = sp_ff;
      nxt_variant = variant_ff;
      nxt_rc_fuse = rc_fuse_ff;
      nxt_long    = long_ff;
      push_we     = 1'b0;
      push_data   = ret_ff[7:0];
      if (core_reset)
      begin
         // Fuses caught while reset is held
         nxt_variant = i_variant_rc;
         nxt_rc_fuse = i_rc_oscillator_select_fuse;
         nxt_long    = i_start_long_fuse;
         nxt_state   = ST_START;
         nxt_start   = start_cycles(i_variant_rc, i_start_long_fuse); // RQ2
         nxt_pc      = PC_RESET;
         nxt_exec_pc = PC_RESET;
         nxt_instr   = INSTR_RESET;
         nxt_valid   = 1'b0;
         nxt_ret     = PC_RESET;
         nxt_sp      = SP_RESET;
      end
      else if (i_ce)
      begin
         if (dacc_ok && i_dacc_we && region == REGION_IO && io_idx == SP_IO_ADDR)
            nxt_sp = i_dacc_wdata; // RQ12
         case (state_ff)
            ST_START:
               if (start_cnt_ff == '0)
                  nxt_state = ST_RUN; // RQ2
               else
                  nxt_start = START_W'(start_cnt_ff - 1'b1);
            ST_RUN:
               if (i_irq_take || i_call)
               begin
                  nxt_ret   = PC_W'(exec_pc_ff + 1'b1); // RQ11
                  nxt_pc    = i_irq_take ? i_irq_vector : rel_target(exec_pc_ff, i_rel_off);
                  nxt_valid = 1'b0;
                  nxt_state = ST_PUSH_LO;
               end
               else if (i_jump)
               begin
                  nxt_pc    = rel_target(exec_pc_ff, i_rel_off); // RQ10
                  nxt_valid = 1'b0;
               end
               else if (i_sleep_req)
               begin
                  nxt_valid = 1'b0;
                  nxt_state = i_sleep_pdown ? ST_PDOWN : ST_IDLE;
               end
               else
               begin
                  // Fetch at pc while instr_ff executes
                  nxt_instr   = i_prog_word; // RQ9
                  nxt_exec_pc = pc_ff; // RQ9
                  nxt_valid   = 1'b1;
                  nxt_pc      = PC_W'(pc_ff + 1'b1);
               end
            ST_PUSH_LO:
            begin
               push_we   = 1'b1; // RQ11
               nxt_sp    = REG_W'(sp_ff - 1'b1); // RQ12
               nxt_state = ST_PUSH_HI;
            end
            ST_PUSH_HI:
            begin
               push_we   = 1'b1; // RQ11
               push_data = {6'h00, ret_ff[9:8]};
               nxt_sp    = REG_W'(sp_ff - 1'b1); // RQ12
               nxt_state = ST_RUN;
            end
            ST_IDLE:
               if (i_irq_req)
                  nxt_state = ST_RUN; // RQ13
            ST_PDOWN:
               if (i_irq_req)
               begin
                  // Oscillator restarts, so the start-up delay runs again
                  nxt_state = ST_START; // RQ14
                  nxt_start = start_cycles(variant_ff, long_ff);
               end
            default: nxt_state = ST_START;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      state_ff     <= nxt_state;
      start_cnt_ff <= nxt_start;
      pc_ff        <= nxt_pc;
      exec_pc_ff   <= nxt_exec_pc;
      instr_ff     <= nxt_instr;
      valid_ff     <= nxt_valid;
      ret_ff       <= nxt_ret;
      sp_ff        <= nxt_sp;
      variant_ff   <= nxt_variant;
      rc_fuse_ff   <= nxt_rc_fuse;
      long_ff      <= nxt_long;
   end

   // Register file and data read path
   logic [REG_W-1:0] regs_ff [NUM_REGS];
   logic [REG_W-1:0] nxt_regs [NUM_REGS];
   logic [REG_W-1:0] rdata_ff, nxt_rdata;
   logic [1:0]       rsel_ff, nxt_rsel;

   always_comb
   begin
      nxt_regs  = regs_ff;
      nxt_rdata = rdata_ff;
      nxt_rsel  = rsel_ff;
      if (core_reset)
      begin
         for (int i = 0; i < NUM_REGS; i++)
            nxt_regs[i] = REG_RESET;
         nxt_rdata = REG_RESET;
         nxt_rsel  = REGION_RF;
      end
      else if (i_ce && cpu_active)
      begin
         if (dacc_ok && i_dacc_we && region == REGION_RF)
            nxt_regs[i_dacc_addr[4:0]] = i_dacc_wdata; // RQ7
         // Execution write-back wins over a data-space store to the same register
         if (i_rf_we)
            nxt_regs[i_rf_wr_idx] = i_rf_wdata; // RQ5
         if (dacc_ok && !i_dacc_we)
         begin
            nxt_rsel  = (region == REGION_IO && io_idx == SP_IO_ADDR) ? REGION_RF : region;
            nxt_rdata = (region == REGION_RF) ? regs_ff[i_dacc_addr[4:0]] : sp_ff;
         end
      end
   end

   always_ff @(posedge i_clk)
   begin
      regs_ff  <= nxt_regs;
      rdata_ff <= nxt_rdata;
      rsel_ff  <= nxt_rsel;
   end

   assign o_op_a       = regs_ff[i_rf_rd_a]; // RQ5
   assign o_op_b       = regs_ff[i_rf_rd_b]; // RQ5
   assign o_ptr_x      = {regs_ff[PTR_X_LO + 5'd1], regs_ff[PTR_X_LO]}; // RQ6
   assign o_ptr_y      = {regs_ff[PTR_Y_LO + 5'd1], regs_ff[PTR_Y_LO]}; // RQ6
   assign o_ptr_z      = {regs_ff[PTR_Z_LO + 5'd1], regs_ff[PTR_Z_LO]}; // RQ6
   assign o_table_addr = o_ptr_z; // RQ6
   assign o_dacc_rdata = (rsel_ff == REGION_IO) ? i_io_rdata :
                         (rsel_ff == REGION_SRAM) ? i_sram_rdata : rdata_ff;

   assign o_io_en      = dacc_ok & i_ce & (region == REGION_IO); // RQ8
   assign o_io_we      = o_io_en & i_dacc_we;
   assign o_io_addr    = io_idx;
   assign o_io_wdata   = i_dacc_wdata;
   // Stack writes share the SRAM port; data accesses only happen in run state
   assign o_sram_we    = push_we | (dacc_ok & i_ce & i_dacc_we & (region == REGION_SRAM));
   assign o_sram_en    = push_we | (dacc_ok & i_ce & (region == REGION_SRAM));
   assign o_sram_addr  = push_we ? sp_ff : i_dacc_addr[REG_W-1:0]; // RQ11
   assign o_sram_wdata = push_we ? push_data : i_dacc_wdata;
   assign o_stack_pointer = sp_ff;
   assign o_prog_addr  = pc_ff;
   assign o_exec_instr = instr_ff;
   assign o_exec_valid = valid_ff;
   assign o_exec_pc    = exec_pc_ff;
   assign o_core_reset = core_reset;
   assign o_cpu_running = cpu_active;

   // Clock select, port masking, status
   logic [PORT_MAX-1:0] pin_s1_ff, pin_s2_ff, nxt_s1, nxt_s2;
   logic [PORT_MAX-1:0] port_o_ff, port_oe_ff, port_pu_ff, port_in_ff;
   logic [PORT_MAX-1:0] nxt_po, nxt_poe, nxt_ppu, nxt_pin, mask;
   core_status_s        status_ff, nxt_status;
   logic                sel_rc, p3_clk;

   assign sel_rc = variant_ff & (rc_fuse_ff == FUSE_PROGRAMMED); // RQ3
   assign p3_clk = variant_ff & ~sel_rc; // RQ4

   always_comb
   begin
      mask = variant_ff ? PORT_MASK_RC : PORT_MASK_XTAL; // RQ15
      mask[PORT_CLK_BIT] = mask[PORT_CLK_BIT] & ~p3_clk; // RQ4
      nxt_s1     = pin_s1_ff;
      nxt_s2     = pin_s2_ff;
      nxt_po     = port_o_ff;
      nxt_poe    = port_oe_ff;
      nxt_ppu    = port_pu_ff;
      nxt_pin    = port_in_ff;
      nxt_status = status_ff;
      if (core_reset)
      begin
         nxt_s1     = '0;
         nxt_s2     = '0;
         nxt_po     = '0;
         nxt_poe    = '0;
         nxt_ppu    = '0;
         nxt_pin    = '0;
         nxt_status = '0;
      end
      else if (i_ce)
      begin
         nxt_s1  = i_port_pin;
         nxt_s2  = pin_s1_ff;
         nxt_po  = i_port_out & mask;
         nxt_poe = i_port_dir & mask;
         nxt_ppu = i_port_pull & ~i_port_dir & mask; // RQ15
         nxt_pin = pin_s2_ff & mask;
         nxt_status.cpu_halt       = (state_ff != ST_RUN) && (state_ff != ST_PUSH_LO)
                                     && (state_ff != ST_PUSH_HI); // RQ13
         nxt_status.osc_stop       = (state_ff == ST_PDOWN); // RQ14
         nxt_status.periph_en      = (state_ff != ST_PDOWN) && (state_ff != ST_START);
         nxt_status.clk_sel_rc     = sel_rc; // RQ3
         nxt_status.port3_is_clock = p3_clk; // RQ4
      end
   end

   always_ff @(posedge i_clk)
   begin
      pin_s1_ff  <= nxt_s1;
      pin_s2_ff  <= nxt_s2;
      port_o_ff  <= nxt_po;
      port_oe_ff <= nxt_poe;
      port_pu_ff <= nxt_ppu;
      port_in_ff <= nxt_pin;
      status_ff  <= nxt_status;
   end

   assign o_port_o  = port_o_ff;
   assign o_port_oe = port_oe_ff;
   assign o_port_pu = port_pu_ff;
   assign o_port_in = port_in_ff;
   assign o_status  = status_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (core_reset);

   start_hold_a: assert property ((state_ff == ST_START && start_cnt_ff != '0) // RQ2
      |-> !o_cpu_running) else $error("core ran before start-up delay ended");
   rc_select_a: assert property (i_ce |=> o_status.clk_sel_rc == // RQ3
      ($past(variant_ff) && $past(rc_fuse_ff) == FUSE_PROGRAMMED)) else $error("bad clock select");
   port3_clock_a: assert property (o_status.port3_is_clock |-> // RQ4
      !o_port_oe[PORT_CLK_BIT] && !o_port_in[PORT_CLK_BIT]) else $error("clock pin used as I/O");
   rf_write_a: assert property ((i_ce && cpu_active && i_rf_we) |=> // RQ5
      regs_ff[$past(i_rf_wr_idx)] == $past(i_rf_wdata)) else $error("write-back lost");
   zptr_write_a: assert property ((i_ce && cpu_active && i_rf_we && i_rf_wr_idx == PTR_Z_LO) // RQ6
      |=> o_table_addr[7:0] == $past(i_rf_wdata)) else $error("pointer low byte wrong");
   io_map_a: assert property ((i_ce && dacc_ok && !i_dacc_io && i_dacc_addr == 16'h0020) // RQ8
      |-> o_io_en && o_io_addr == 6'h00) else $error("I/O base mapped wrongly");
   fetch_pipe_a: assert property ((i_ce && cpu_active && !i_jump && !i_call && !i_irq_take // RQ9
      && !i_sleep_req) |=> o_exec_valid && o_exec_instr == $past(i_prog_word)
      && o_exec_pc == $past(o_prog_addr)) else $error("prefetch not executed next");
   rel_jump_a: assert property ((i_ce && cpu_active && i_jump && !i_call && !i_irq_take) // RQ10
      |=> o_prog_addr == PC_W'($past(exec_pc_ff) + $past(i_rel_off[PC_W-1:0]) + 1'b1)
      && !o_exec_valid) else $error("relative jump target wrong");
   call_push_a: assert property ((i_ce && cpu_active && i_call && !i_irq_take) |=> // RQ11
      o_sram_we && o_sram_addr == $past(sp_ff) && o_sram_wdata == ret_ff[7:0])
      else $error("return address not pushed");
   sp_step_a: assert property ((i_ce && state_ff == ST_PUSH_HI) |=> // RQ12
      o_stack_pointer == REG_W'($past(sp_ff) - 1'b1) && state_ff == ST_RUN)
      else $error("stack pointer step wrong");
   idle_halt_a: assert property ((state_ff == ST_IDLE) |=> o_status.cpu_halt // RQ13
      && o_status.periph_en) else $error("idle state flags wrong");
   pdown_keep_a: assert property ((state_ff == ST_PDOWN && !i_irq_req) |=> // RQ14
      o_status.osc_stop && !o_status.periph_en && $stable(o_ptr_z))
      else $error("power-down lost state");

   push_seen_c: cover property (state_ff == ST_PUSH_LO ##1 state_ff == ST_PUSH_HI);
   pdown_wake_c: cover property (state_ff == ST_PDOWN ##1 state_ff == ST_START);
   idle_wake_c: cover property (state_ff == ST_IDLE ##1 state_ff == ST_RUN);
endmodule // cpu_core_map
`default_nettype wire

// ==== src/core_map_pkg.sv ====
// Shared constants and types for the core register file, data-space map and core control.
// Assumes one 100 MHz clock and static fuse inputs that are stable while the core runs.
package core_map_pkg;
   localparam int NUM_REGS  = 32;
   localparam int REG_W     = 8;
   localparam int PC_W      = 10;
   localparam int ADDR_W    = 16;
   localparam int PORT_MAX  = 5;

   localparam logic [ADDR_W-1:0] REG_SPACE_END = 16'h001f;
   localparam logic [ADDR_W-1:0] IO_SPACE_BASE = 16'h0020;
   localparam logic [ADDR_W-1:0] IO_SPACE_END  = 16'h005f;
   localparam logic [1:0]        REGION_RF     = 2'h0;
   localparam logic [1:0]        REGION_IO     = 2'h1;
   localparam logic [1:0]        REGION_SRAM   = 2'h2;

   localparam logic [4:0] PTR_X_LO   = 5'h1a;
   localparam logic [4:0] PTR_Y_LO   = 5'h1c;
   localparam logic [4:0] PTR_Z_LO   = 5'h1e;
   localparam logic [5:0] SP_IO_ADDR = 6'h3d;

   localparam logic [REG_W-1:0]  SP_RESET    = 8'h00;
   localparam logic [REG_W-1:0]  REG_RESET   = 8'h00;
   localparam logic [15:0]       INSTR_RESET = 16'h0000;
   localparam logic [PC_W-1:0]   PC_RESET    = 10'h000;

   localparam int RESET_LOW_CYCLES = 2;

   localparam int CLK_PERIOD_NS  = 10;
   localparam int XTAL_SHORT_MS  = 1;
   localparam int XTAL_LONG_MS   = 16;
   localparam int RC_START_US    = 16;
   localparam int XTAL_SHORT_CYC = XTAL_SHORT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int XTAL_LONG_CYC  = XTAL_LONG_MS * 1000000 / CLK_PERIOD_NS;
   localparam int RC_START_CYC   = RC_START_US * 1000 / CLK_PERIOD_NS;
   localparam int START_W        = 21;

   localparam logic                FUSE_PROGRAMMED = 1'b0;
   localparam logic [PORT_MAX-1:0] PORT_MASK_XTAL  = 5'h07;
   localparam logic [PORT_MAX-1:0] PORT_MASK_RC    = 5'h1f;
   localparam int                  PORT_CLK_BIT    = 3;

   typedef enum logic [5:0] {
      ST_START   = 6'b000001,
      ST_RUN     = 6'b000010,
      ST_PUSH_LO = 6'b000100,
      ST_PUSH_HI = 6'b001000,
      ST_IDLE    = 6'b010000,
      ST_PDOWN   = 6'b100000
   } core_state_e;

   typedef struct packed {
      logic cpu_halt;
      logic osc_stop;
      logic periph_en;
      logic clk_sel_rc;
      logic port3_is_clock;
   } core_status_s;
endpackage

// ==== src/reset_qualifier.sv ====
// Reset pin qualifier: synchronises the active-low reset pin and counts low samples.
// Assumes the pin is asynchronous; a frozen clock enable counts as a stopped oscillator.
`timescale 1ns/1ns
`default_nettype none
module reset_qualifier
   import core_map_pkg::*;
#(
   parameter int LOW_CYCLES = RESET_LOW_CYCLES
)(
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_ce,
   input  wire logic i_reset_pin_n,
   output logic      o_core_reset
);
   localparam int CNT_W = $clog2(LOW_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(LOW_CYCLES);

   logic             pin_s1_ff, nxt_s1;
   logic             pin_s2_ff, nxt_s2;
   logic [CNT_W-1:0] cnt_ff, nxt_cnt;
   logic             rst_ff, nxt_rst;

   always_comb
   begin
      nxt_s1  = pin_s1_ff;
      nxt_s2  = pin_s2_ff;
      nxt_cnt = cnt_ff;
      if (i_reset)
      begin
         nxt_s1  = 1'b1;
         nxt_s2  = 1'b1;
         nxt_cnt = '0;
      end
      else if (i_ce)
      begin
         nxt_s1 = i_reset_pin_n;
         nxt_s2 = pin_s1_ff;
         if (pin_s2_ff)
            nxt_cnt = '0; // RQ16
         else if (cnt_ff != CNT_FULL)
            nxt_cnt = CNT_W'(cnt_ff + 1'b1); // RQ16
      end
      nxt_rst = i_reset | (nxt_cnt == CNT_FULL); // RQ1
   end

   always_ff @(posedge i_clk)
   begin
      pin_s1_ff <= nxt_s1;
      pin_s2_ff <= nxt_s2;
      cnt_ff    <= nxt_cnt;
      rst_ff    <= nxt_rst;
   end

   assign o_core_reset = rst_ff;

   pin_qualify_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ1
      (!pin_s2_ff && cnt_ff == CNT_FULL - 1 && i_ce) |=> o_core_reset)
      else $error("reset not raised after enough low samples");
   pin_release_a: assert property (@(posedge i_clk) disable iff (i_reset) // RQ16
      (pin_s2_ff && i_ce) |=> !o_core_reset)
      else $error("reset held while pin sampled high");
endmodule // reset_qualifier
`default_nettype wire

// ==== verification/cpu_core_map_tb_top.sv ====
// Testbench for cpu_core_map: drives the core ports directly and checks outputs.
// Assumes crystal start-up counts shortened to 20 and 40 cycles; program word follows address.
`timescale 1ns/1ns
`default_nettype none
module cpu_core_map_tb_top import core_map_pkg::*;;
   logic i_clk = '0, i_reset = '1, i_reset_pin_n = '1, i_variant_rc = '0, i_start_long_fuse = '0;
   logic i_rc_oscillator_select_fuse = '0, i_jump = '0, i_call = '0, i_irq_take = '0;
   logic i_irq_req = '0, i_sleep_req = '0, i_sleep_pdown = '0, i_rf_we = '0;
   logic i_dacc_en = '0, i_dacc_we = '0, i_dacc_io = '0, i_ce = '1;
   logic [11:0] i_rel_off = '0;
   logic [4:0] i_rf_wr_idx = '0, i_rf_rd_a = '0, i_rf_rd_b = '0;
   logic [4:0] i_port_out = '0, i_port_dir = '0, i_port_pull = '0, o_port_o, o_port_oe, o_port_pu;
   logic [4:0] o_port_in, i_port_pin = 5'h0a;
   logic [7:0] i_rf_wdata = '0, i_dacc_wdata = '0, o_op_a, o_op_b, o_dacc_rdata, o_io_wdata;
   logic [7:0] o_sram_addr, o_sram_wdata, o_stack_pointer;
   logic [15:0] i_dacc_addr = '0, o_exec_instr, o_ptr_x, o_ptr_y, o_ptr_z, o_table_addr;
   logic [9:0] o_prog_addr, o_exec_pc;
   logic [5:0] o_io_addr;
   logic o_exec_valid, o_io_en, o_io_we, o_sram_en, o_sram_we, o_core_reset, o_cpu_running;
   core_status_s o_status;
   wire logic [15:0] i_prog_word;
   int n_fail = 0, check_count = 0;
   // Word tagged with its address so a wrong fetch slot shows up
   assign i_prog_word = {6'h2a, o_prog_addr};
   cpu_core_map #(.XTAL_SHORT_COUNT(20), .XTAL_LONG_COUNT(40)) cpu_core_map_inst (.i_clk, .i_reset,
      .i_ce, .i_reset_pin_n, .i_variant_rc, .i_rc_oscillator_select_fuse, .i_start_long_fuse,
      .i_prog_word, .o_prog_addr, .o_exec_instr, .o_exec_valid, .o_exec_pc, .i_jump, .i_call,
      .i_rel_off, .i_irq_take, .i_irq_vector(10'h100), .i_irq_req, .i_sleep_req, .i_sleep_pdown,
      .i_rf_we, .i_rf_wr_idx, .i_rf_wdata, .i_rf_rd_a, .i_rf_rd_b, .o_op_a, .o_op_b, .o_ptr_x,
      .o_ptr_y, .o_ptr_z, .o_table_addr, .i_dacc_en, .i_dacc_we, .i_dacc_io, .i_dacc_addr,
      .i_dacc_wdata, .o_dacc_rdata, .o_io_en, .o_io_we, .o_io_addr, .o_io_wdata,
      .i_io_rdata(8'h5a), .o_sram_en, .o_sram_we, .o_sram_addr, .o_sram_wdata,
      .i_sram_rdata(8'ha5), .o_stack_pointer, .i_port_out, .i_port_dir, .i_port_pull,
      .i_port_pin, .o_port_o, .o_port_oe, .o_port_pu, .o_port_in, .o_status,
      .o_core_reset, .o_cpu_running);
   always #5 i_clk = ~i_clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run;
      if (n_fail == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Bounded wait; a run that never starts ends the test
   task automatic wait_run(output int n);
      for (n = 0; n < 2000 && o_cpu_running !== 1'h1; n++) @(posedge i_clk);
      if (n == 2000)
      begin
         n_fail++;
         complete_run;
      end
      #1;
   endtask
   task automatic boot(input logic rc, input logic fuse, input logic lng, output int n);
      @(posedge i_clk);
      i_reset <= '1; i_variant_rc <= rc; i_rc_oscillator_select_fuse <= fuse; i_start_long_fuse <= lng;
      repeat (10) @(posedge i_clk);
      i_reset <= '0;
      wait_run(n);
   endtask
   task automatic dacc(input logic io, input logic we, input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_dacc_en <= '1; i_dacc_io <= io; i_dacc_we <= we; i_dacc_addr <= a; i_dacc_wdata <= d;
      @(posedge i_clk);
      i_dacc_en <= '0;
      #1;
   endtask
   task automatic wreg(input logic [4:0] i, input logic [7:0] d);
      @(posedge i_clk);
      i_rf_we <= '1; i_rf_wr_idx <= i; i_rf_wdata <= d;
      @(posedge i_clk);
      i_rf_we <= '0;
      #1;
   endtask
   initial
   begin
      int n;
      logic [9:0] e, r;
      logic [7:0] s;
      boot('0, '0, '0, n); chk(n < 40, 1);
      @(posedge i_clk);
      i_port_out <= 5'h1f; i_port_dir <= 5'h03; i_port_pull <= 5'h1f; i_rf_rd_a <= 5'h1a; i_rf_rd_b <= 5'h1f;
      tick(2); chk(o_port_o, 5'h07); chk(o_port_pu, 5'h04); chk(o_port_in, 5'h02);
      for (int k = 26; k < 32; k++) wreg(k[4:0], 8'h10 + k[7:0]);
      chk(o_op_a, 8'h2a); chk(o_op_b, 8'h2f); chk(o_ptr_x, 16'h2b2a); chk(o_ptr_y, 16'h2d2c);
      chk(o_ptr_z, 16'h2f2e); chk(o_table_addr, 16'h2f2e);
      dacc('0, '1, 16'h001a, 8'h77); chk(o_op_a, 8'h77); dacc('0, '0, 16'h001f, 8'h00);
      chk(o_dacc_rdata, 8'h2f);
      for (int k = 0; k < 2; k++)
      begin
         @(posedge i_clk);
         i_dacc_en <= '1; i_dacc_io <= k[0]; i_dacc_we <= '1; i_dacc_addr <= k ? 16'h0005 : 16'h0025;
         #1 chk(o_io_en, 1); chk(o_io_addr, 6'h05);
      end
      dacc('1, '1, 16'h003d, 8'h7f); chk(o_stack_pointer, 8'h7f);
      chk(o_exec_valid, 1); chk(o_exec_instr, {6'h2a, o_exec_pc}); chk(o_prog_addr, o_exec_pc + 10'h1);
      @(posedge i_clk);
      i_jump <= '1; i_rel_off <= 12'hffe;
      #1 e = o_exec_pc - 10'h1;
      @(posedge i_clk);
      i_jump <= '0;
      #1 chk(o_prog_addr, e);
      for (int c = 0; c < 2; c++)
      begin
         @(posedge i_clk);
         i_call <= c == 0; i_irq_take <= c == 1; i_rel_off <= 12'h010;
         #1 e = o_exec_pc; r = e + 10'h1; s = o_stack_pointer;
         @(posedge i_clk);
         i_call <= '0; i_irq_take <= '0;
         #1 chk(o_sram_we, 1); chk(o_sram_addr, s); chk(o_sram_wdata, r[7:0]);
         tick(1); chk(o_sram_addr, s - 8'h1); chk(o_sram_wdata, {6'h00, r[9:8]});
         e = c ? 10'h100 : e + 10'h11;
         tick(1); chk(o_stack_pointer, s - 8'h2); chk(o_prog_addr, e);
      end
      for (int p = 0; p < 2; p++)
      begin
         @(posedge i_clk);
         i_sleep_req <= '1; i_sleep_pdown <= p[0];
         @(posedge i_clk);
         i_sleep_req <= '0;
         tick(2); chk(o_cpu_running, 0); chk(o_status.cpu_halt, 1); chk(o_status.osc_stop, p);
         @(posedge i_clk);
         i_irq_req <= '1;
         wait_run(n);
         i_irq_req <= '0;
      end
      chk(o_ptr_z, 16'h2f2e);
      @(posedge i_clk);
      i_reset_pin_n <= '0;
      @(posedge i_clk);
      i_reset_pin_n <= '1;
      tick(6); chk(o_core_reset, 0);
      i_reset_pin_n <= '0;
      tick(8); chk(o_core_reset, 1);
      i_reset_pin_n <= '1;
      tick(8); chk(o_core_reset, 0);
      boot('1, '1, '0, n); chk(o_status.port3_is_clock, 1); chk(o_status.clk_sel_rc, 0);
      boot('1, '0, '0, n); chk(o_status.clk_sel_rc, 1); chk(o_port_o, 5'h1f);
      boot('0, '0, '1, n); chk(n >= 40, 1);
      complete_run;
   end
endmodule // cpu_core_map_tb_top
`default_nettype wire
